// ### common/fifo_flag_pkg.sv
// shared constants and types for the bidirectional fifo flag and mailbox block
package fifo_flag_pkg;
    localparam int DATA_W = 36;
    // depth of each direction per variant; the build picks one
    localparam int DEPTH_SMALL = 256;
    localparam int DEPTH_MID = 512;
    localparam int DEPTH_LARGE = 1024;
    localparam int FIFO_DEPTH = DEPTH_SMALL;
    localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
    localparam logic [CNT_W-1:0] DEPTH_CNT = CNT_W'(FIFO_DEPTH);
    // fixed flag offsets; programming of offsets lives outside this block
    localparam logic [CNT_W-1:0] AE_OFFSET = CNT_W'(8);
    localparam logic [CNT_W-1:0] AF_OFFSET = CNT_W'(8);
    localparam logic [CNT_W-1:0] AF_LIMIT = DEPTH_CNT - AF_OFFSET;

    // port b bus width
    typedef enum logic [2:0] {
        WIDTH_LONG = 3'b001,
        WIDTH_WORD = 3'b010,
        WIDTH_BYTE = 3'b100
    } width_t;

    localparam logic [1:0] LAST_PART_WORD = 2'h1;
    localparam logic [1:0] LAST_PART_BYTE = 2'h3;
    localparam logic [1:0] PART_RST = 2'h0;

    localparam logic [DATA_W-1:0] MASK_WORD = 36'h0_0003_ffff;
    localparam logic [DATA_W-1:0] MASK_BYTE = 36'h0_0000_01ff;
    localparam logic [DATA_W-1:0] DATA_RST = 36'h0_0000_0000;

    // flag values after reset: both fifos empty, mailboxes empty
    localparam logic FULL_FLAG_RST = 1'b1;
    localparam logic ALMOST_EMPTY_RST = 1'b0;
    localparam logic ALMOST_FULL_RST = 1'b1;
    localparam logic MAIL_FLAG_RST = 1'b1;
endpackage : fifo_flag_pkg

// ### verilog/word_fifo.sv
// synchronous first-word-visible fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [LW-1:0] level_q;
    logic push;
    logic pop;

    assign in_ready = level_q != LW'(DEPTH);
    assign out_valid = level_q != '0;
    assign out_data = mem[rd_ptr_q];
    assign level = level_q;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_ff @(posedge mclk)
    begin
        if (push)
        begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            level_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : AW'(wr_ptr_q + 1'b1);
            end
            if (pop)
            begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : AW'(rd_ptr_q + 1'b1);
            end
            level_q <= LW'(level_q + LW'(push) - LW'(pop));
        end
    end
endmodule : word_fifo
`default_nettype wire

// ### verilog/bidir_fifo_flag_sync_mailbox.sv
// two-direction fifo pair with bus matching, mailboxes and cross-port flag timing
// Operation
// - fifo1 full released next port a edge
// - fifo1 full timed from last-part read
// - fall-through: fifo2 input ready next b edge
// - fifo2 ready/full drop on last-part write
// - standard: fifo2 full released next b edge
// - fifo1 almost-empty released next b edge
// - fifo1 almost-empty set on last-part read
// - fifo2 almost-empty released next a edge
// - fifo2 almost-empty timed from last-part write
// - fifo1 almost-full released next a edge
// - fifo1 almost-full timed from last-part read
// - fifo2 almost-full set on last-part write
// - almost-full against variant depth 256/512/1024
// - word width: mailbox one carries bits 0-17
// - byte width: mailbox one carries bits 0-8
// - word width: mailbox two carries bits 0-17
// - byte width: mailbox two carries bits 0-8
// - endian latched on first edge after reset release; widths held static
`timescale 1ns/1ps
`default_nettype none
module bidir_fifo_flag_sync_mailbox (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic port_a_clock,
    input wire logic port_b_clock,
    input wire logic port_a_chip_select_n,
    input wire logic port_a_write_not_read,
    input wire logic port_a_mailbox_select,
    input wire logic port_a_enable,
    input wire logic [fifo_flag_pkg::DATA_W-1:0] port_a_din,
    output logic [fifo_flag_pkg::DATA_W-1:0] port_a_dout,
    input wire logic port_b_chip_select_n,
    input wire logic port_b_write_not_read,
    input wire logic port_b_mailbox_select,
    input wire logic port_b_enable,
    input wire logic [fifo_flag_pkg::DATA_W-1:0] port_b_din,
    output logic [fifo_flag_pkg::DATA_W-1:0] port_b_dout,
    input wire logic bus_match_select,
    input wire logic size_select,
    input wire logic endian_select,
    input wire logic fall_through_mode,
    output logic fifo1_full_flag,
    output logic fifo1_almost_full,
    output logic fifo2_almost_empty,
    output logic mailbox_two_full,
    output logic fifo2_full_flag,
    output logic fifo2_input_ready,
    output logic fifo1_almost_empty,
    output logic fifo2_almost_full,
    output logic mailbox_one_full
);
    import fifo_flag_pkg::*;

    width_t width_mode;
    logic big_endian_q;
    logic endian_taken_q;
    logic a_act, b_act;
    logic a_fifo1_wr, a_fifo2_rd, a_mailbox_one_reg_wr, a_mailbox_two_reg_rd;
    logic b_fifo1_rd, b_fifo2_wr, b_mailbox_one_reg_rd, b_mailbox_two_reg_wr;
    logic [1:0] rd_part_q;
    logic [1:0] wr_part_q;
    logic rd_last, wr_last;
    logic [1:0] rd_lane, wr_lane;
    logic [DATA_W-1:0] asm_q;
    logic [DATA_W-1:0] asm_d;
    logic [DATA_W-1:0] width_mask;
    logic [DATA_W-1:0] b_read_part;
    logic f1_in_ready, f1_out_valid, f2_in_ready, f2_out_valid;
    logic [DATA_W-1:0] f1_out_data, f2_out_data;
    logic [CNT_W-1:0] lvl1, lvl2;
    logic push1, pop1, push2, pop2;
    logic [CNT_W-1:0] lvl1_after_a, lvl1_after_b, lvl2_after_a, lvl2_after_b;
    logic [DATA_W-1:0] mailbox_one_reg_q, mailbox_two_reg_q;
    logic mb1_full_q, mb2_full_q;
    logic fifo2_space;

    // width selects are static during operation, so decode them directly
    always_comb
    begin
        if (!bus_match_select)
        begin
            width_mode = WIDTH_LONG;
        end
        else if (size_select)
        begin
            width_mode = WIDTH_BYTE;
        end
        else
        begin
            width_mode = WIDTH_WORD;
        end
    end

    // endian taken on the first edge after release, never from the reset branch
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            big_endian_q <= 1'b0;
            endian_taken_q <= 1'b0;
        end
        else if (!endian_taken_q)
        begin
            big_endian_q <= endian_select;
            endian_taken_q <= 1'b1;
        end
    end

    assign a_act = port_a_clock & port_a_enable & ~port_a_chip_select_n;
    assign b_act = port_b_clock & port_b_enable & ~port_b_chip_select_n;
    assign a_fifo1_wr = a_act & port_a_write_not_read & ~port_a_mailbox_select;
    assign a_fifo2_rd = a_act & ~port_a_write_not_read & ~port_a_mailbox_select;
    assign a_mailbox_one_reg_wr = a_act & port_a_write_not_read & port_a_mailbox_select;
    assign a_mailbox_two_reg_rd = a_act & ~port_a_write_not_read & port_a_mailbox_select;
    assign b_fifo1_rd = b_act & port_b_write_not_read & ~port_b_mailbox_select;
    assign b_fifo2_wr = b_act & ~port_b_write_not_read & ~port_b_mailbox_select;
    assign b_mailbox_one_reg_rd = b_act & port_b_write_not_read & port_b_mailbox_select;
    assign b_mailbox_two_reg_wr = b_act & ~port_b_write_not_read & port_b_mailbox_select;

    function automatic logic is_last(input width_t mode, input logic [1:0] part);
        unique case (mode)
            WIDTH_LONG: is_last = 1'b1;
            WIDTH_WORD: is_last = part == LAST_PART_WORD;
            WIDTH_BYTE: is_last = part == LAST_PART_BYTE;
        endcase
    endfunction : is_last

    // big endian moves the most significant lane first
    function automatic logic [1:0] lane_of(input width_t mode, input logic [1:0] part,
                                           input logic big);
        unique case (mode)
            WIDTH_LONG: lane_of = 2'h0;
            WIDTH_WORD: lane_of = big ? 2'(LAST_PART_WORD - part) : part;
            WIDTH_BYTE: lane_of = big ? 2'(LAST_PART_BYTE - part) : part;
        endcase
    endfunction : lane_of

    assign rd_last = is_last(width_mode, rd_part_q);
    assign wr_last = is_last(width_mode, wr_part_q);
    assign rd_lane = lane_of(width_mode, rd_part_q, big_endian_q);
    assign wr_lane = lane_of(width_mode, wr_part_q, big_endian_q);

    // only the last part of a long word moves the fifo pointers
    assign push1 = a_fifo1_wr & f1_in_ready;
    assign pop1 = b_fifo1_rd & f1_out_valid & rd_last;
    assign push2 = b_fifo2_wr & f2_in_ready & wr_last;
    assign pop2 = a_fifo2_rd & f2_out_valid;

    always_comb
    begin
        unique case (width_mode)
            WIDTH_LONG: width_mask = {DATA_W{1'b1}};
            WIDTH_WORD: width_mask = MASK_WORD;
            WIDTH_BYTE: width_mask = MASK_BYTE;
        endcase
    end

    // port b read lane selection; unused upper bits read as zero
    always_comb
    begin
        b_read_part = DATA_RST;
        unique case (width_mode)
            WIDTH_LONG: b_read_part = f1_out_data;
            WIDTH_WORD: b_read_part[17:0] = rd_lane[0] ? f1_out_data[35:18] : f1_out_data[17:0];
            WIDTH_BYTE: b_read_part[8:0] = f1_out_data[9*rd_lane +: 9];
        endcase
    end

    // merge the current port b write part into the long word being built
    always_comb
    begin
        asm_d = asm_q;
        unique case (width_mode)
            WIDTH_LONG: asm_d = port_b_din;
            WIDTH_WORD:
            begin
                if (wr_lane[0])
                begin
                    asm_d[35:18] = port_b_din[17:0];
                end
                else
                begin
                    asm_d[17:0] = port_b_din[17:0];
                end
            end
            WIDTH_BYTE: asm_d[9*wr_lane +: 9] = port_b_din[8:0];
        endcase
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rd_part_q <= PART_RST;
            wr_part_q <= PART_RST;
            asm_q <= DATA_RST;
        end
        else
        begin
            if (b_fifo1_rd && f1_out_valid)
            begin
                rd_part_q <= rd_last ? PART_RST : 2'(rd_part_q + 1'b1);
            end
            if (b_fifo2_wr && f2_in_ready)
            begin
                wr_part_q <= wr_last ? PART_RST : 2'(wr_part_q + 1'b1);
                asm_q <= asm_d;
            end
        end
    end

    word_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) fifo1_a_to_b (
        .mclk(mclk),
        .resetn(resetn),
        .in_valid(a_fifo1_wr),
        .in_data(port_a_din),
        .in_ready(f1_in_ready),
        .out_valid(f1_out_valid),
        .out_data(f1_out_data),
        .out_ready(b_fifo1_rd & rd_last),
        .level(lvl1)
    );

    word_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) fifo2_b_to_a (
        .mclk(mclk),
        .resetn(resetn),
        .in_valid(b_fifo2_wr & wr_last),
        .in_data(asm_d),
        .in_ready(f2_in_ready),
        .out_valid(f2_out_valid),
        .out_data(f2_out_data),
        .out_ready(a_fifo2_rd),
        .level(lvl2)
    );

    // each port sees its own access at once but the far port's access only
    // through the registered level, so a far edge in the same mclk cycle
    // lands one observing edge later: that is the skew-limit miss
    assign lvl1_after_a = CNT_W'(lvl1 + CNT_W'(push1));
    assign lvl1_after_b = CNT_W'(lvl1 - CNT_W'(pop1));
    assign lvl2_after_a = CNT_W'(lvl2 - CNT_W'(pop2));
    assign lvl2_after_b = CNT_W'(lvl2 + CNT_W'(push2));
    assign fifo2_space = lvl2_after_b != DEPTH_CNT;

    // flags observed on port a
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            fifo1_full_flag <= FULL_FLAG_RST;
            fifo1_almost_full <= ALMOST_FULL_RST;
            fifo2_almost_empty <= ALMOST_EMPTY_RST;
        end
        else if (port_a_clock)
        begin
            fifo1_full_flag <= lvl1_after_a != DEPTH_CNT;
            fifo1_almost_full <= lvl1_after_a < AF_LIMIT;
            fifo2_almost_empty <= lvl2_after_a > AE_OFFSET;
        end
    end

    // flags observed on port b
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            fifo2_full_flag <= FULL_FLAG_RST;
            fifo2_input_ready <= 1'b0;
            fifo1_almost_empty <= ALMOST_EMPTY_RST;
            fifo2_almost_full <= ALMOST_FULL_RST;
        end
        else if (port_b_clock)
        begin
            fifo2_input_ready <= fall_through_mode & fifo2_space;
            fifo2_full_flag <= fall_through_mode | fifo2_space;
            fifo1_almost_empty <= lvl1_after_b > AE_OFFSET;
            fifo2_almost_full <= lvl2_after_b < AF_LIMIT;
        end
    end

    // a write to a full mailbox is dropped; set still beats a same-cycle clear
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            mailbox_one_reg_q <= DATA_RST;
            mb1_full_q <= 1'b0;
        end
        else if (a_mailbox_one_reg_wr && !mb1_full_q)
        begin
            mailbox_one_reg_q <= port_a_din & width_mask;
            mb1_full_q <= 1'b1;
        end
        else if (b_mailbox_one_reg_rd)
        begin
            mb1_full_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            mailbox_two_reg_q <= DATA_RST;
            mb2_full_q <= 1'b0;
        end
        else if (b_mailbox_two_reg_wr && !mb2_full_q)
        begin
            mailbox_two_reg_q <= port_b_din & width_mask;
            mb2_full_q <= 1'b1;
        end
        else if (a_mailbox_two_reg_rd)
        begin
            mb2_full_q <= 1'b0;
        end
    end

    // mailbox flags are resampled by the reading port's edge
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            mailbox_one_full <= MAIL_FLAG_RST;
            mailbox_two_full <= MAIL_FLAG_RST;
        end
        else
        begin
            if (port_b_clock)
            begin
                mailbox_one_full <= ~mb1_full_q;
            end
            if (port_a_clock)
            begin
                mailbox_two_full <= ~mb2_full_q;
            end
        end
    end

    // read data registers; an empty fifo read leaves the output as it was
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            port_a_dout <= DATA_RST;
            port_b_dout <= DATA_RST;
        end
        else
        begin
            if (pop2)
            begin
                port_a_dout <= f2_out_data;
            end
            else if (a_mailbox_two_reg_rd)
            begin
                port_a_dout <= mailbox_two_reg_q;
            end
            if (b_fifo1_rd && f1_out_valid)
            begin
                port_b_dout <= b_read_part;
            end
            else if (b_mailbox_one_reg_rd)
            begin
                port_b_dout <= mailbox_one_reg_q;
            end
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    ffa_set_a: assert property (port_a_clock && push1 && !pop1 && lvl1 == DEPTH_CNT - 1'b1
        |=> !fifo1_full_flag) else $error("fifo1 full flag not set on filling write");
    part_pop_a: assert property (b_fifo1_rd && f1_out_valid && width_mode != WIDTH_LONG
        && !rd_last |=> lvl1 == $past(lvl1) + CNT_W'($past(push1)))
        else $error("fifo1 popped before last part");
    irb_mode_a: assert property (!fall_through_mode && port_b_clock |=> !fifo2_input_ready)
        else $error("input ready raised outside fall-through");
    ffb_drop_a: assert property (port_b_clock && push2 && !pop2 && lvl2 == DEPTH_CNT - 1'b1
        |=> !fifo2_input_ready && (fall_through_mode || !fifo2_full_flag))
        else $error("fifo2 full not signalled on filling write");
    ffb_release_a: assert property (!fall_through_mode && port_b_clock && lvl2 < DEPTH_CNT
        && !push2 |=> fifo2_full_flag) else $error("fifo2 full flag not released");
    aeb_set_a: assert property (port_b_clock && pop1 && !push1 && lvl1 == AE_OFFSET + 1'b1
        |=> !fifo1_almost_empty) else $error("fifo1 almost empty not set");
    aea_rise_a: assert property (port_a_clock && !pop2 && lvl2 > AE_OFFSET
        |=> fifo2_almost_empty) else $error("fifo2 almost empty not released");
    afa_rise_a: assert property (port_a_clock && !push1 && lvl1 < AF_LIMIT
        |=> fifo1_almost_full) else $error("fifo1 almost full not released");
    afb_set_a: assert property (port_b_clock && push2 && !pop2 && lvl2 == AF_LIMIT - 1'b1
        |=> !fifo2_almost_full) else $error("fifo2 almost full not set");
    mailbox_one_reg_width_a: assert property (b_mailbox_one_reg_rd && width_mode == WIDTH_BYTE && !a_mailbox_one_reg_wr
        |=> port_b_dout[35:9] == '0 && port_b_dout[8:0] == $past(mailbox_one_reg_q[8:0]))
        else $error("mailbox one byte width leak");
    mailbox_one_full_flag_a: assert property (a_mailbox_one_reg_wr && !mb1_full_q ##1 port_b_clock && !b_mailbox_one_reg_rd
        |=> !mailbox_one_full) else $error("mailbox one flag not set");
endmodule : bidir_fifo_flag_sync_mailbox
`default_nettype wire

// ### sim/port_clock_gen.sv
// port clock pulse source standing in for the hosts on both ports
`timescale 1ns/1ps
`default_nettype none
module port_clock_gen (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic coincide,
    output logic port_a_clock,
    output logic port_b_clock
);
    logic phase_q;

    // free running like a host clock; never stops between accesses
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            phase_q <= 1'b0;
        else
            phase_q <= ~phase_q;
    end

    assign port_a_clock = phase_q;
    // coincident pulses model two edges closer than the skew limit
    assign port_b_clock = coincide ? phase_q : ~phase_q;
endmodule : port_clock_gen
`default_nettype wire

// ### sim/tb_top.sv
// bench for the fifo pair flags, bus matching and mailboxes
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import fifo_flag_pkg::*;
    logic mclk, resetn, coincide, port_a_clock, port_b_clock, p;
    logic port_a_chip_select_n, port_a_write_not_read, port_a_mailbox_select, port_a_enable;
    logic port_b_chip_select_n, port_b_write_not_read, port_b_mailbox_select, port_b_enable;
    logic bus_match_select, size_select, endian_select, fall_through_mode;
    logic [DATA_W-1:0] port_a_din, port_a_dout, port_b_din, port_b_dout, m, d;
    logic fifo1_full_flag, fifo1_almost_full, fifo2_almost_empty, mailbox_two_full;
    logic fifo2_full_flag, fifo2_input_ready, fifo1_almost_empty, fifo2_almost_full;
    logic mailbox_one_full;
    int err_count, comparisons, n, sh, s;

    port_clock_gen port_clock_gen_i (.mclk, .resetn, .coincide, .port_a_clock, .port_b_clock);
    bidir_fifo_flag_sync_mailbox bidir_fifo_flag_sync_mailbox_i (
        .mclk, .resetn, .port_a_clock, .port_b_clock, .port_a_chip_select_n,
        .port_a_write_not_read, .port_a_mailbox_select, .port_a_enable, .port_a_din,
        .port_a_dout, .port_b_chip_select_n, .port_b_write_not_read, .port_b_mailbox_select,
        .port_b_enable, .port_b_din, .port_b_dout, .bus_match_select, .size_select,
        .endian_select, .fall_through_mode, .fifo1_full_flag, .fifo1_almost_full,
        .fifo2_almost_empty, .mailbox_two_full, .fifo2_full_flag, .fifo2_input_ready,
        .fifo1_almost_empty, .fifo2_almost_full, .mailbox_one_full);

    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask : chk

    task automatic fl(input logic got, input logic exp);
        chk({35'h0, got}, {35'h0, exp});
    endtask : fl

    task automatic cyc(input int c);
        repeat (c) @(posedge mclk);
        #1;
    endtask : cyc

    function automatic logic room(input logic pb, input logic ft);
        return pb ? (ft ? fifo2_input_ready : fifo2_full_flag) : fifo1_full_flag;
    endfunction : room

    function automatic logic afl(input logic pb);
        return pb ? fifo2_almost_full : fifo1_almost_full;
    endfunction : afl

    // request held until the edge where the port's own clock pulse is seen
    task automatic acc(input logic pb, input logic wn, input logic mb,
        input logic [DATA_W-1:0] dv);
        int t;
        @(posedge mclk);
        if (pb)
        begin
            {port_b_enable, port_b_chip_select_n} <= 2'b10;
            {port_b_write_not_read, port_b_mailbox_select, port_b_din} <= {wn, mb, dv};
        end
        else
        begin
            {port_a_enable, port_a_chip_select_n} <= 2'b10;
            {port_a_write_not_read, port_a_mailbox_select, port_a_din} <= {wn, mb, dv};
        end
        t = 0;
        do
        begin
            @(posedge mclk);
            t++;
        end
        while (!(pb ? port_b_clock : port_a_clock) && t < 20);
        // released data lines flip so a stale value cannot pass for a match
        if (pb)
            {port_b_enable, port_b_chip_select_n, port_b_din} <= {2'b01, ~dv};
        else
            {port_a_enable, port_a_chip_select_n, port_a_din} <= {2'b01, ~dv};
    endtask : acc

    task automatic wr(input logic pb, input logic mb, input logic [DATA_W-1:0] dv);
        acc(pb, ~pb, mb, dv);
    endtask : wr

    task automatic rd(input logic pb, input logic mb, input logic [DATA_W-1:0] exp);
        acc(pb, pb, mb, ~exp);
        cyc(1);
        chk(pb ? port_b_dout : port_a_dout, exp);
    endtask : rd

    task automatic rst(input logic bm, input logic sz, input logic en, input logic ft);
        @(posedge mclk);
        resetn <= 1'b0;
        {bus_match_select, size_select, endian_select, fall_through_mode} <= {bm, sz, en, ft};
        cyc(5);
        chk(36'({fifo1_full_flag, fifo1_almost_full, fifo2_almost_empty, mailbox_two_full,
            fifo2_full_flag, fifo2_input_ready, fifo1_almost_empty, fifo2_almost_full,
            mailbox_one_full}), 36'h0_0000_01b3);
        chk(port_a_dout | port_b_dout, DATA_RST);
        @(posedge mclk);
        resetn <= 1'b1;
        cyc(2);
    endtask : rst

    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test

    initial
    begin
        {resetn, coincide, port_a_enable, port_b_enable} = 4'b0000;
        {port_a_chip_select_n, port_a_write_not_read, port_a_mailbox_select} = 3'b100;
        {port_b_chip_select_n, port_b_write_not_read, port_b_mailbox_select} = 3'b100;
        {bus_match_select, size_select, endian_select, fall_through_mode} = 4'b0010;
        port_a_din = DATA_RST;
        port_b_din = ~DATA_RST;
        err_count = 0;
        comparisons = 0;
        rst(1'b0, 1'b0, 1'b1, 1'b0);
        for (int k = 0; k < 2; k++)
        begin
            p = k[0];
            for (int i = 0; i < 9; i++)
                wr(p, 1'b0, 36'h9_0000_0000 + 36'(i));
            cyc(6);
            fl(p ? fifo2_almost_empty : fifo1_almost_empty, 1'b1);
            for (int i = 0; i < 9; i++)
            begin
                rd(~p, 1'b0, 36'h9_0000_0000 + 36'(i));
                if (i == 0)
                    fl(p ? fifo2_almost_empty : fifo1_almost_empty, 1'b0);
            end
        end
        $display("almost-empty test done");
        for (int f = 0; f < 2; f++)
        begin
            coincide <= f[0];
            for (int k = 0; k < 2; k++)
            begin
                rst(1'b0, 1'b0, 1'b1, f[0]);
                p = k[0];
                // the last write finds the fifo full and must be dropped
                for (int i = 0; i < 257; i++)
                    wr(p, 1'b0, 36'h5_0000_0000 + 36'(i));
                fl(room(p, f[0]), 1'b0);
                fl(afl(p), 1'b0);
                rd(~p, 1'b0, 36'h5_0000_0000);
                cyc(8);
                fl(room(p, f[0]), 1'b1);
                for (int i = 1; i < 256; i++)
                begin
                    rd(~p, 1'b0, 36'h5_0000_0000 + 36'(i));
                    if (i == 7 || i == 8)
                    begin
                        cyc(8);
                        fl(afl(p), 1'(i == 8));
                    end
                end
                rd(~p, 1'b0, 36'h5_0000_00ff); // empty read keeps the last word
            end
        end
        $display("full and almost-full test done");
        coincide <= 1'b0;
        for (int w = 0; w < 3; w++)
        begin
            n = (w == 0) ? 1 : 2 * w;
            sh = 36 / n;
            m = (w == 0) ? ~DATA_RST : (w == 1) ? MASK_WORD : MASK_BYTE;
            rst(1'(w != 0), 1'(w == 2), 1'(w != 1), 1'b0);
            for (int k = 0; k < 2; k++)
            begin
                p = k[0];
                d = p ? 36'h5_a3c3_0f0e : 36'ha_5c3c_f0f1;
                wr(p, 1'b1, d);
                wr(p, 1'b1, ~d);
                cyc(6);
                fl(p ? mailbox_two_full : mailbox_one_full, 1'b0);
                rd(~p, 1'b1, d & m);
                cyc(6);
                fl(p ? mailbox_two_full : mailbox_one_full, 1'b1);
            end
            d = 36'ha_5c3c_f0f1;
            for (int i = 0; i < 9; i++)
                wr(1'b0, 1'b0, d);
            cyc(6);
            for (int j = 0; j < n; j++)
            begin
                fl(fifo1_almost_empty, 1'b1);
                s = sh * ((w == 1) ? j : n - 1 - j);
                rd(1'b1, 1'b0, (d >> s) & m);
            end
            fl(fifo1_almost_empty, 1'b0);
            d = 36'h5_a3c3_0f0e;
            for (int i = 0; i < 9 * n; i++)
            begin
                s = sh * ((w == 1) ? i % n : n - 1 - i % n);
                if (i == 9 * n - 1)
                begin
                    cyc(6);
                    fl(fifo2_almost_empty, 1'b0);
                end
                wr(1'b1, 1'b0, ((d >> s) & m) | ~m);
            end
            cyc(6);
            fl(fifo2_almost_empty, 1'b1);
            rd(1'b0, 1'b0, d);
            $display("width %0d test done", w);
        end
        stop_test();
    end

    // about seven times the span the tests need
    initial
    begin
        #1_000_000;
        err_count++;
        $display("watchdog expired");
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
